// ==== logic/spi_buf_pkg.sv ====
/*
  Constants and carrier types for the buffered serial data port.
  Assumes an APB master on pclk and a serial peer on the pin side.
*/
package spi_buf_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IEN = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_IGNORE = 1;
  localparam int CTRL_BUFFER_MODE_ENABLE = 2;
  localparam int FL_RXC = 7;
  localparam int FL_TXC = 6;
  localparam int FL_DRE = 5;
  localparam int FL_SS = 4;
  localparam int FL_OVF = 0;
  localparam int FL_IF = 7;
  localparam logic [2:0] SCK_HALF = 3'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef struct packed {
    logic sck;
    logic mosi;
  } pin_out_t;
endpackage : spi_buf_pkg

// ==== logic/spi_buffered_flags_data_port.sv ====
/*
  Buffered serial port: flags, data mapping, shifter and APB slave.
  Assumes pclk-synchronous pins; sck mode 0, MSB first.
*/
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module spi_buffered_flags_data_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ss_n_in,
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  output spi_buf_pkg::pin_out_t pins_out,
  output logic sck_oe,
  output logic mosi_oe,
  output logic miso_out,
  output logic irq
);
  import spi_buf_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b100
  } st_t;

  st_t st_q, st_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [7:0] ien_q, ien_d;
  logic rxc_q, rxc_d, txc_q, txc_d, ssf_q, ssf_d, ovf_q, ovf_d;
  logic [7:0] sh_q, sh_d, txb_q, txb_d, rx0_q, rx0_d, rx1_q, rx1_d;
  logic txf_q, txf_d, v0_q, v0_d, v1_q, v1_d, pend_q, pend_d;
  logic [2:0] bit_q, bit_d, div_q, div_d;
  logic sck_q, sck_d, sckp_q, sckp_d, ssp_q, ssp_d;
  logic [31:0] prdata_d;
  logic irq_d;
  logic wr, rd, master, buffer_mode_enable, done, sample, shift_ev, slv_active;
  logic pready_d, rxb_q, rxb_d;

  // One wait state so registered read data stands at the pready edge
  assign pready_d = psel & penable & ~pready;
  assign wr = psel & penable & pready & pwrite;
  assign rd = psel & penable & pready & ~pwrite;
  assign master = ctrl_q[CTRL_MASTER];
  assign buffer_mode_enable = ctrl_q[CTRL_BUFFER_MODE_ENABLE];
  assign slv_active = ~master & ~ss_n_in;

  // Master clock generation and bit counting
  always_comb begin
    st_d = st_q;
    div_d = div_q + 3'h1;
    sck_d = sck_q;
    bit_d = bit_q;
    sample = 1'b0;
    shift_ev = 1'b0;
    done = 1'b0;
    sckp_d = sck_in;
    ssp_d = ss_n_in;
    case (st_q)
      ST_IDLE: begin
        div_d = 3'h0;
        bit_d = 3'h0;
        sck_d = 1'b0;
        if (master && pend_q) begin
          st_d = ST_LOW;
        end
      end
      ST_LOW: begin
        if (!master) begin
          st_d = ST_IDLE;
        end else if (div_q == SCK_HALF) begin
          div_d = 3'h0;
          sck_d = 1'b1;
          sample = 1'b1;
          st_d = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (!master) begin
          st_d = ST_IDLE;
        end else if (div_q == SCK_HALF) begin
          div_d = 3'h0;
          sck_d = 1'b0;
          shift_ev = 1'b1;
          bit_d = bit_q + 3'h1;
          if (bit_q == BIT_LAST) begin
            done = 1'b1;
            st_d = ST_IDLE;
          end else begin
            st_d = ST_LOW;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // Slave side follows the external clock edges
    if (slv_active && sck_in && !sckp_q) begin
      sample = 1'b1;
    end
    if (slv_active && !sck_in && sckp_q) begin
      shift_ev = 1'b1;
      bit_d = bit_q + 3'h1;
      done = (bit_q == BIT_LAST);
    end
    if (!master && ss_n_in) begin
      bit_d = 3'h0;
    end
  end

  // Data path, flags and register writes
  always_comb begin
    ctrl_d = ctrl_q;
    ien_d = ien_q;
    sh_d = sh_q;
    txb_d = txb_q;
    txf_d = txf_q;
    rx0_d = rx0_q;
    rx1_d = rx1_q;
    v0_d = v0_q;
    v1_d = v1_q;
    pend_d = pend_q;
    txc_d = txc_q;
    ssf_d = ssf_q;
    ovf_d = ovf_q;
    rxb_d = rxb_q;
    if (wr && paddr == ADDR_CTRL) begin
      ctrl_d = pwdata[2:0];
    end
    if (wr && paddr == ADDR_IEN) begin
      ien_d = pwdata[7:0];
    end
    // Write-one clears; hardware sets below take priority
    if (wr && paddr == ADDR_FLAGS) begin
      if (pwdata[FL_TXC]) txc_d = 1'b0;
      if (pwdata[FL_SS]) ssf_d = 1'b0;
      if (pwdata[FL_OVF]) ovf_d = 1'b0;
      if (pwdata[FL_RXC] && buffer_mode_enable) begin
        v0_d = 1'b0;
        v1_d = 1'b0;
      end
    end
    if (rd && paddr == ADDR_DATA) begin
      ovf_d = 1'b0;
      if (buffer_mode_enable) begin
        rx0_d = rx1_q;
        v0_d = v1_q;
        v1_d = 1'b0;
      end
    end
    // Capture on the rising edge, shift on the falling one, so the
    // output bit never moves while the far side samples it
    if (sample) begin
      rxb_d = master ? miso_in : mosi_in;
    end
    if (shift_ev) begin
      sh_d = {sh_q[6:0], rxb_q};
    end
    if (done) begin
      pend_d = 1'b0;
      if (!buffer_mode_enable) begin
        rx0_d = sh_d;
        v0_d = 1'b1;
      end else if (!v0_d) begin
        rx0_d = sh_d;
        v0_d = 1'b1;
      end else if (!v1_d) begin
        rx1_d = sh_d;
        v1_d = 1'b1;
      end else if (txf_q || pend_q) begin
        ovf_d = 1'b1;
      end
      if (txf_q) begin
        sh_d = txb_q;
        txf_d = 1'b0;
        pend_d = 1'b1;
      end else begin
        txc_d = 1'b1;
      end
    end
    if (wr && paddr == ADDR_DATA) begin
      if (buffer_mode_enable && (pend_q || st_q != ST_IDLE)) begin
        txb_d = pwdata[7:0];
        txf_d = 1'b1;
      end else begin
        sh_d = pwdata[7:0];
        pend_d = 1'b1;
      end
    end
    // Select pulled low while master and not ignored: hand over to slave
    if (master && !ctrl_q[CTRL_IGNORE] && !ss_n_in && ssp_q) begin
      ctrl_d[CTRL_MASTER] = 1'b0;
      ssf_d = 1'b1;
    end
  end

  // Read mux and interrupt request
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (psel && penable && !pready) begin
      case (paddr)
        ADDR_CTRL: prdata_d = {29'h0, ctrl_q};
        ADDR_IEN: prdata_d = {24'h0, ien_q};
        ADDR_FLAGS: begin
          if (buffer_mode_enable) begin
            prdata_d[FL_RXC] = v0_q;
            prdata_d[FL_TXC] = txc_q;
            prdata_d[FL_DRE] = ~txf_q;
            prdata_d[FL_SS] = ssf_q;
            prdata_d[FL_OVF] = ovf_q;
          end else begin
            prdata_d[FL_IF] = v0_q | ssf_q;
          end
        end
        ADDR_DATA: prdata_d = {24'h0, rx0_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (buffer_mode_enable) begin
      irq_d = (v0_q & ien_q[FL_RXC]) | (txc_q & ien_q[FL_TXC])
        | (~txf_q & ien_q[FL_DRE]) | (ssf_q & ien_q[FL_SS]);
    end else begin
      irq_d = (v0_q | ssf_q) & ien_q[0];
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      ctrl_q <= 3'h0;
      ien_q <= 8'h00;
      sh_q <= 8'h00;
      txb_q <= 8'h00;
      rx0_q <= 8'h00;
      rx1_q <= 8'h00;
      {txf_q, v0_q, v1_q, pend_q} <= 4'h0;
      {txc_q, ssf_q, ovf_q} <= 3'h0;
      bit_q <= 3'h0;
      div_q <= 3'h0;
      {sck_q, sckp_q} <= 2'h0;
      ssp_q <= 1'b1;
      rxb_q <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      pins_out <= '0;
      sck_oe <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      ien_q <= ien_d;
      sh_q <= sh_d;
      txb_q <= txb_d;
      rx0_q <= rx0_d;
      rx1_q <= rx1_d;
      {txf_q, v0_q, v1_q, pend_q} <= {txf_d, v0_d, v1_d, pend_d};
      {txc_q, ssf_q, ovf_q} <= {txc_d, ssf_d, ovf_d};
      bit_q <= bit_d;
      div_q <= div_d;
      {sck_q, sckp_q} <= {sck_d, sckp_d};
      ssp_q <= ssp_d;
      rxb_q <= rxb_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= 1'b0;
      pins_out.sck <= sck_d;
      pins_out.mosi <= sh_d[7];
      sck_oe <= ctrl_d[CTRL_MASTER];
      mosi_oe <= ctrl_d[CTRL_MASTER];
      miso_out <= sh_d[7];
      irq <= irq_d;
    end
  end

  // Checks
  a_dre_write_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == ADDR_DATA && buffer_mode_enable && pend_q) |=> txf_q)
    else $error("tx buffer not filled by write");
  a_ovf_read_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == ADDR_DATA && !done) |=> !ovf_q)
    else $error("overflow not cleared by read");
  a_takeover_slave: assert property (@(posedge pclk) disable iff (!presetn)
    (master && !ctrl_q[CTRL_IGNORE] && !ss_n_in && ssp_q && !wr) |=> (!master && ssf_q))
    else $error("select takeover missed");
  a_ignore_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (master && ctrl_q[CTRL_IGNORE] && !wr) |=> master)
    else $error("master lost despite ignore");
  a_rx_irq_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (buffer_mode_enable && v0_q && ien_q[FL_RXC]) |=> irq)
    else $error("rx interrupt not requested");
  a_dre_irq_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (buffer_mode_enable && !txf_q && ien_q[FL_DRE]) |=> irq)
    else $error("empty interrupt not requested");
  a_txc_on_done: assert property (@(posedge pclk) disable iff (!presetn)
    (done && !txf_q) |=> txc_q)
    else $error("transfer complete not set");
  a_ovf_when_full: assert property (@(posedge pclk) disable iff (!presetn)
    (done && buffer_mode_enable && v0_q && v1_q && txf_q && !rd && !wr) |=> ovf_q)
    else $error("overflow not set");
  c_master_xfer: cover property (@(posedge pclk) disable iff (!presetn) done && master);
  c_overflow: cover property (@(posedge pclk) disable iff (!presetn) $rose(ovf_q));
  c_takeover: cover property (@(posedge pclk) disable iff (!presetn) $rose(ssf_q));
endmodule : spi_buffered_flags_data_port
`default_nettype wire

// ==== bench/spi_peer_model.sv ====
/*
  Serial peer for master-mode traffic: samples mosi, returns a reply.
  Assumes mode 0 from the block, sck idle low between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic [7:0] reply,
  output logic miso,
  output logic [7:0] last_rx,
  output int n_frames
);
  logic [7:0] rx_q;
  logic [7:0] sh_q;
  logic [2:0] rise_q;
  logic [2:0] fall_q;
  initial begin
    rx_q = 8'h00;
    sh_q = 8'h00;
    rise_q = 3'h0;
    fall_q = 3'h0;
    last_rx = 8'h00;
    n_frames = 0;
  end
  // Sample on rising sck, MSB first
  always @(posedge sck) begin
    rx_q <= {rx_q[6:0], mosi};
    rise_q <= rise_q + 3'h1;
    if (rise_q == 3'h7) begin
      last_rx <= {rx_q[6:0], mosi};
      n_frames <= n_frames + 1;
    end
  end
  // Move miso on falling sck only, so a rising-edge sampler never races
  always @(negedge sck) begin
    fall_q <= fall_q + 3'h1;
    sh_q <= (fall_q == 3'h0) ? {reply[6:0], 1'b0} : {sh_q[6:0], 1'b0};
  end
  assign miso = (fall_q == 3'h0) ? reply[7] : sh_q[7];
endmodule : spi_peer_model
`default_nettype wire

// ==== bench/spi_buffered_flags_data_port_tb.sv ====
/*
  Self-checking bench: APB master, serial peer, flag and data checks.
  Assumes the package constants and one-cycle-late read data.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module spi_buffered_flags_data_port_tb;
  import spi_buf_pkg::*;
  typedef struct packed {logic [7:0] ctrl; logic [7:0] tx; logic [7:0] rx;} row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ss_n, miso;
  logic sck_oe, mosi_oe, miso_out, irq;
  logic [7:0] paddr, reply, last_rx;
  logic [31:0] pwdata, prdata, rd;
  pin_out_t pins;
  int n_frames, n0, mismatches = 0, n_tests = 0;
  row_t rows [5] = '{'{8'h05, 8'hA5, 8'h3C}, '{8'h05, 8'h00, 8'hFF}, '{8'h05, 8'hFF, 8'h00},
                     '{8'h01, 8'h5A, 8'hC3}, '{8'h01, 8'h81, 8'h7E}};
  spi_buffered_flags_data_port i_spi_buffered_flags_data_port (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ss_n_in(ss_n), .sck_in(1'b0),
    .mosi_in(1'b0), .miso_in(miso), .pins_out(pins), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
    .miso_out(miso_out), .irq(irq));
  spi_peer_model i_spi_peer_model (.sck(pins.sck), .mosi(pins.mosi), .reply(reply),
    .miso(miso), .last_rx(last_rx), .n_frames(n_frames));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task complete_run();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      mismatches++;
      complete_run();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Bounded wait for the peer to see one whole byte
  task xfer(input logic [7:0] tx, input logic [7:0] rep);
    int k;
    reply = rep;
    n0 = n_frames;
    apb(1'b1, ADDR_DATA, {24'h0, tx});
    for (k = 0; k < 800 && n_frames == n0; k++) @(posedge pclk);
    if (k >= 800) begin
      mismatches++;
      complete_run();
    end
    repeat (10) @(posedge pclk);
  endtask : xfer
  task settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle
  task reset_dut();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask : reset_dut
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    {paddr, reply, pwdata} = '0;
    ss_n = 1'b1;
    reset_dut();
    apb(1'b0, ADDR_FLAGS, 32'h0);
    `CHK("flags reset", 32'h0, rd)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("slverr", 1'b0, pslverr)
    $display("test reset done");
    // Ordinary transfers, buffered and unbuffered
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ADDR_CTRL, {24'h0, rows[i].ctrl});
      xfer(rows[i].tx, rows[i].rx);
      `CHK("mosi byte", rows[i].tx, last_rx)
      if (rows[i].ctrl[CTRL_BUFFER_MODE_ENABLE]) begin
        apb(1'b0, ADDR_FLAGS, 32'h0);
        `CHK("flags", 32'hE0, rd)
      end
      apb(1'b0, ADDR_DATA, 32'h0);
      `CHK("rx byte", {24'h0, rows[i].rx}, rd)
    end
    $display("test rows done");
    // Interrupt requests follow flags and enables
    apb(1'b1, ADDR_CTRL, 32'h05);
    xfer(8'h11, 8'h22);
    apb(1'b1, ADDR_IEN, 32'h80);
    settle();
    `CHK("irq rx", 1'b1, irq)
    apb(1'b1, ADDR_FLAGS, 32'h80);
    settle();
    `CHK("irq rx clr", 1'b0, irq)
    apb(1'b1, ADDR_IEN, 32'h20);
    settle();
    `CHK("irq dre", 1'b1, irq)
    apb(1'b1, ADDR_IEN, 32'h00);
    settle();
    `CHK("irq off", 1'b0, irq)
    apb(1'b1, ADDR_FLAGS, 32'h40);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    `CHK("txc clr", 32'h20, rd)
    $display("test irq done");
    // Third byte with both entries full is lost
    xfer(8'h01, 8'h31);
    xfer(8'h02, 8'h32);
    xfer(8'h03, 8'h33);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    `CHK("ovf set", 1'b1, rd[FL_OVF])
    apb(1'b0, ADDR_DATA, 32'h0);
    `CHK("oldest", 32'h31, rd)
    apb(1'b0, ADDR_FLAGS, 32'h0);
    `CHK("ovf clr", 1'b0, rd[FL_OVF])
    apb(1'b1, ADDR_FLAGS, 32'hD1);
    $display("test overflow done");
    // Select takeover, ignored then honoured
    apb(1'b1, ADDR_CTRL, 32'h07);
    ss_n <= 1'b0;
    settle();
    `CHK("ignore oe", 1'b1, sck_oe)
    apb(1'b0, ADDR_FLAGS, 32'h0);
    `CHK("no ss flag", 1'b0, rd[FL_SS])
    ss_n <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h05);
    ss_n <= 1'b0;
    settle();
    `CHK("takeover oe", 1'b0, sck_oe)
    apb(1'b0, ADDR_FLAGS, 32'h0);
    `CHK("ss flag", 1'b1, rd[FL_SS])
    ss_n <= 1'b1;
    apb(1'b1, ADDR_FLAGS, 32'h10);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    `CHK("ss clr", 1'b0, rd[FL_SS])
    $display("test takeover done");
    // Slave write only stages the byte
    apb(1'b1, ADDR_CTRL, 32'h04);
    n0 = n_frames;
    apb(1'b1, ADDR_DATA, 32'h66);
    repeat (200) @(posedge pclk);
    `CHK("no frame", n0, n_frames)
    `CHK("sck idle", 1'b0, pins.sck)
    reset_dut();
    apb(1'b0, ADDR_FLAGS, 32'h0);
    `CHK("flags rerst", 32'h0, rd)
    $display("test slave and reset done");
    complete_run();
  end
endmodule : spi_buffered_flags_data_port_tb
`default_nettype wire
